// ---- design/dae_defs.vh ----
// constants for the dual cipher accelerator
// Contract
// - keys of 128 or 256 bits, all modes
// - ECB CBC CTR CCM GCM GMAC, both directions
// - two single-transfer DMA requests per engine
// - secure engine ECB: 528 or 743 cycles
// - fast engine ECB: 51 or 75 cycles
// - secure picks four key sources; fast software only
// - software key registers are write-only
// - boot key locked after write until reset
// - hardware keys never visible to software
// - tamper or protection regression clears boot key
// - derived key variant follows security context
// - hidden path copies secure key to fast
// - secure engine masks with random number input
// - one 128-bit block per operation
// - ECB/CBC decrypt uses last round key
// - 256-bit key, loaded atomically
// - 128-bit IV in four words
// - one word in, one word out buffer
// - word swap of 1, 8, 16, 32 bits
// - suspend, process other message, resume
// - wrapped key and shared key modes
// - breach makes hardware-derived keys unusable
`ifndef DAE_DEFS_VH
`define DAE_DEFS_VH
`define DAE_SEL_SEC   2'h0
`define DAE_SEL_FAST  2'h1
`define DAE_SEL_BOOT  2'h2
`define DAE_CTRL      8'h00
`define DAE_STAT      8'h04
`define DAE_CLR       8'h08
`define DAE_DIN       8'h0C
`define DAE_DOUT      8'h10
`define DAE_LAST_ENG  8'h10
`define DAE_BOOT_LAST 8'h1C
`define DAE_C_EN      0
`define DAE_C_DEC     1
`define DAE_C_MODE    4:2
`define DAE_C_KSZ     5
`define DAE_C_SWAP    7:6
`define DAE_C_KSEL    9:8
`define DAE_C_KMODE   11:10
`define DAE_C_DMAI    12
`define DAE_C_DMAO    13
`define DAE_C_SUSP    14
`define DAE_C_SECCTX  15
`define DAE_C_SHARE   16
`define DAE_FAST_MASK 17'h070FF
`define DAE_M_ECB     3'h0
`define DAE_M_CBC     3'h1
`define DAE_M_GMAC    3'h4
`define DAE_KM_WRAP   2'h1
`define DAE_KM_SHARE  2'h2
`define DAE_SEC_L128  10'h210
`define DAE_SEC_L256  10'h2E7
`define DAE_FST_L128  10'h033
`define DAE_FST_L256  10'h04B
`define DAE_CTX_S     32'hA5C3_96E1
`define DAE_CTX_N     32'h3C5A_0F87
`endif

// ---- design/dae_top.v ----
// two block cipher engines with shared key path and APB registers
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "dae_defs.vh"

module dae_engine #(
    parameter [9:0] LAT128 = `DAE_FST_L128,
    parameter [9:0] LAT256 = `DAE_FST_L256,
    parameter       MASK   = 0
) (
    // clock and reset
    input  wire         clk,
    input  wire         rstn,
    // configuration
    input  wire         en,
    input  wire         dec,
    input  wire [2:0]   mode,
    input  wire         ksz,
    input  wire [1:0]   swap,
    input  wire         dmai,
    input  wire         dmao,
    input  wire         susp,
    input  wire         hide,
    input  wire [255:0] key,
    input  wire         key_ok,
    input  wire [31:0]  rng,
    // register strobes
    input  wire         din_stb,
    input  wire [31:0]  din,
    input  wire         dout_stb,
    input  wire         iv_stb,
    input  wire [1:0]   iv_idx,
    input  wire         clr_stb,
    input  wire [1:0]   clr,
    // results and status
    output wire [31:0]  dout,
    output wire [127:0] iv_q,
    output wire         ccf,
    output wire         err,
    output wire         busy,
    output wire         dreq_i,
    output wire         dreq_o,
    output wire [127:0] res_blk,
    output wire         res_stb
);
    reg  [127:0] blk_r;
    reg  [127:0] res_r;
    reg  [127:0] iv_r;
    reg  [1:0]   icnt_r;
    reg  [2:0]   ocnt_r;
    reg  [9:0]   cnt_r;
    reg          busy_r;
    reg          ccf_r;
    reg          err_r;
    reg          stb_r;
    reg  [127:0] px;
    reg          pd;
    reg  [127:0] r_nxt;
    reg  [127:0] iv_nxt;
    wire [127:0] kf;
    wire [3:0]   nr;
    wire [127:0] m;
    wire [127:0] py;
    wire         ok_in;
    wire         done;

    function [31:0] swp;
        input [31:0] w;
        input [1:0]  s;
        integer i;
        begin
            swp = w;
            case (s)
                2'h1: swp = {w[15:0], w[31:16]};
                2'h2: swp = {w[7:0], w[15:8], w[23:16], w[31:24]};
                2'h3: for (i = 0; i < 32; i = i + 1) swp[i] = w[31-i];
                default: swp = w;
            endcase
        end
    endfunction

    // round model: rotate and key mix; d walks it backward
    function [127:0] ciph;
        input [127:0] x;
        input [127:0] k;
        input [3:0]   n;
        input         d;
        integer i;
        reg [127:0] s;
        reg [127:0] t;
        begin
            s = x;
            for (i = 0; i < 14; i = i + 1)
                if (i < n)
                begin
                    t = s ^ k;
                    s = d ? {t[0], t[127:1]} : ({s[126:0], s[127]} ^ k);
                end
            ciph = s;
        end
    endfunction

    function [127:0] rot;
        input [127:0] x;
        input [3:0]   n;
        input         d;
        integer i;
        reg [127:0] s;
        begin
            s = x;
            for (i = 0; i < 14; i = i + 1)
                if (i < n)
                    s = d ? {s[0], s[127:1]} : {s[126:0], s[127]};
            rot = s;
        end
    endfunction

    assign kf = ksz ? (key[127:0] ^ key[255:128]) : key[127:0];
    assign nr = ksz ? 4'hE : 4'hA;
    // share of random mask never leaves the datapath unmasked
    assign m = (MASK != 0) ? {4{rng}} : 128'h0;
    // inverse walk starts from the last round key
    assign py = ciph(px ^ m, kf, nr, pd) ^ rot(m, nr, pd);

    always @*
    begin
        px = iv_r;
        pd = 1'b0;
        r_nxt = blk_r ^ py;
        iv_nxt = {iv_r[127:32], iv_r[31:0] + 32'h1};
        case (mode)
            `DAE_M_ECB:
            begin
                px = blk_r;
                pd = dec;
                r_nxt = py;
                iv_nxt = iv_r;
            end
            `DAE_M_CBC:
            begin
                px = dec ? blk_r : (blk_r ^ iv_r);
                pd = dec;
                r_nxt = dec ? (py ^ iv_r) : py;
                iv_nxt = dec ? blk_r : py;
            end
            `DAE_M_GMAC:
            begin
                px = blk_r ^ iv_r;
                r_nxt = py;
                iv_nxt = py;
            end
            default:
            begin
                px = iv_r;
                pd = 1'b0;
                r_nxt = blk_r ^ py;
                iv_nxt = {iv_r[127:32], iv_r[31:0] + 32'h1};
            end
        endcase
    end

    // suspend stops intake at once, even mid-block; IV holds chain state
    assign ok_in = en & ~busy_r & (ocnt_r == 3'h0) & ~susp;
    assign done = busy_r & (cnt_r == 10'h0);

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            blk_r <= 128'h0;
            res_r <= 128'h0;
            iv_r <= 128'h0;
            icnt_r <= 2'h0;
            ocnt_r <= 3'h0;
            cnt_r <= 10'h0;
            busy_r <= 1'b0;
            ccf_r <= 1'b0;
            err_r <= 1'b0;
            stb_r <= 1'b0;
        end
        else
        begin
            stb_r <= 1'b0;
            if (clr_stb & clr[0])
                ccf_r <= 1'b0;
            if (clr_stb & clr[1])
                err_r <= 1'b0;
            if (busy_r)
                cnt_r <= cnt_r - 10'h1;
            if (!en)
            begin
                icnt_r <= 2'h0;
                ocnt_r <= 3'h0;
                busy_r <= 1'b0;
            end
            else if (done)
            begin
                busy_r <= 1'b0;
                res_r <= r_nxt;
                iv_r <= iv_nxt;
                ocnt_r <= hide ? 3'h0 : 3'h4;
                ccf_r <= 1'b1;
                stb_r <= 1'b1;
            end
            if ((din_stb | dout_stb | iv_stb) & busy_r)
                err_r <= 1'b1;
            else if (din_stb & ok_in)
            begin
                blk_r <= {blk_r[95:0], swp(din, swap)};
                icnt_r <= icnt_r + 2'h1;
                if (icnt_r == 2'h3)
                begin
                    if (key_ok)
                    begin
                        busy_r <= 1'b1;
                        cnt_r <= (ksz ? LAT256 : LAT128) - 10'h1;
                    end
                    else
                        err_r <= 1'b1;
                end
            end
            else if (dout_stb & (ocnt_r != 3'h0))
            begin
                res_r <= {res_r[95:0], 32'h0};
                ocnt_r <= ocnt_r - 3'h1;
            end
            else if (iv_stb)
                iv_r[iv_idx*32 +: 32] <= din;
        end
    end

    assign dout = (ocnt_r != 3'h0) ? swp(res_r[127:96], swap) : 32'h0;
    assign iv_q = iv_r;
    assign ccf = ccf_r;
    assign err = err_r;
    assign busy = busy_r;
    assign dreq_i = dmai & ok_in;
    assign dreq_o = dmao & ~busy_r & (ocnt_r != 3'h0);
    assign res_blk = res_r;
    assign res_stb = stb_r;
endmodule // dae_engine

module dae_top (
    // clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // APB slave
    input  wire [11:0]  paddr,
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [31:0]  pwdata,
    output wire [31:0]  prdata,
    output wire         pready,
    output wire         pslverr,
    // hardware key and random source
    input  wire [255:0] root_device_key,
    input  wire [31:0]  rng_data,
    // security events, asynchronous pins
    input  wire         tamper,
    input  wire         rdp_regression,
    input  wire         security_breach,
    // DMA requests, bit 0 secure, bit 1 fast
    output wire [1:0]   dma_in_req,
    output wire [1:0]   dma_out_req
);
    reg  [16:0]  ctrl_r [0:1];
    reg  [255:0] swkey_r [0:1];
    reg  [1:0]   kok_r;
    reg  [1:0]   hwk_r;
    reg  [255:0] boot_key_r;
    reg          boot_lock_r;
    reg          breach_r;
    reg          wh_r;
    reg  [2:0]   s1_r;
    reg  [2:0]   s2_r;
    reg  [31:0]  prdata_r;
    reg          perr_r;
    reg  [31:0]  rd_nxt;
    reg  [255:0] sec_key;
    reg          sec_ok;
    wire [1:0]   sel = paddr[9:8];
    wire [7:0]   off = paddr[7:0];
    wire         es = sel[0];
    wire         is_eng = ~sel[1];
    wire         is_key = (off[7:5] == 3'h1);
    wire         is_iv = (off[7:4] == 4'h4);
    wire [2:0]   kidx = paddr[4:2];
    wire [1:0]   hit = {is_eng & es, is_eng & ~es};
    wire         bad;
    wire         wr;
    wire         rd;
    wire [16:0]  cs = ctrl_r[0];
    wire [16:0]  ca = ctrl_r[es];
    wire [255:0] dkey;
    wire [1:0]   eok;
    wire [511:0] ekey;
    wire [63:0]  dout_w;
    wire [255:0] iv_w;
    wire [1:0]   ccf_w;
    wire [1:0]   err_w;
    wire [1:0]   busy_w;
    wire [255:0] res_w;
    wire [1:0]   rstb_w;
    wire         tamper_s = s2_r[0];
    wire         rdp_s = s2_r[1];
    wire         breach_s = s2_r[2];
    wire         hide_s;
    wire         unwrap;

    assign bad = (paddr[11:10] != 2'h0) | (paddr[1:0] != 2'h0) | (sel == 2'h3) |
                 (is_eng ? ~((off <= `DAE_LAST_ENG) | is_key | is_iv) : (off > `DAE_BOOT_LAST));
    assign wr = psel & penable & pwrite & ~bad;
    assign rd = psel & penable & ~pwrite & ~bad;

    // context picks the derived key variant
    assign dkey = root_device_key ^ {8{cs[`DAE_C_SECCTX] ? `DAE_CTX_S : `DAE_CTX_N}};

    always @*
    begin
        case (cs[`DAE_C_KSEL])
            2'h1:
            begin
                sec_key = dkey;
                sec_ok = ~breach_r;
            end
            2'h2:
            begin
                sec_key = boot_key_r;
                sec_ok = boot_lock_r & ~breach_r;
            end
            2'h3:
            begin
                sec_key = dkey ^ boot_key_r;
                sec_ok = boot_lock_r & ~breach_r;
            end
            default:
            begin
                sec_key = swkey_r[0];
                sec_ok = kok_r[0] & ~(hwk_r[0] & breach_r);
            end
        endcase
    end

    // fast engine sees only its own key registers
    assign eok = {kok_r[1] & ~(hwk_r[1] & breach_r), sec_ok};
    assign ekey = {swkey_r[1], sec_key};
    assign hide_s = (cs[`DAE_C_KMODE] != 2'h0) & cs[`DAE_C_DEC];
    assign unwrap = rstb_w[0] & hide_s;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : eng
            dae_engine #(
                .LAT128 (g == 0 ? `DAE_SEC_L128 : `DAE_FST_L128),
                .LAT256 (g == 0 ? `DAE_SEC_L256 : `DAE_FST_L256),
                .MASK   (g == 0 ? 1 : 0)
            ) u_eng (
                .clk      (pclk),
                .rstn     (presetn),
                .en       (ctrl_r[g][`DAE_C_EN]),
                .dec      (ctrl_r[g][`DAE_C_DEC]),
                .mode     (ctrl_r[g][`DAE_C_MODE]),
                .ksz      (ctrl_r[g][`DAE_C_KSZ]),
                .swap     (ctrl_r[g][`DAE_C_SWAP]),
                .dmai     (ctrl_r[g][`DAE_C_DMAI]),
                .dmao     (ctrl_r[g][`DAE_C_DMAO]),
                .susp     (ctrl_r[g][`DAE_C_SUSP]),
                .hide     (g == 0 ? hide_s : 1'b0),
                .key      (ekey[g*256 +: 256]),
                .key_ok   (eok[g]),
                .rng      (rng_data),
                .din_stb  (wr & hit[g] & (off == `DAE_DIN)),
                .din      (pwdata),
                .dout_stb (rd & hit[g] & (off == `DAE_DOUT)),
                .iv_stb   (wr & hit[g] & is_iv),
                .iv_idx   (paddr[3:2]),
                .clr_stb  (wr & hit[g] & (off == `DAE_CLR)),
                .clr      (pwdata[1:0]),
                .dout     (dout_w[g*32 +: 32]),
                .iv_q     (iv_w[g*128 +: 128]),
                .ccf      (ccf_w[g]),
                .err      (err_w[g]),
                .busy     (busy_w[g]),
                .dreq_i   (dma_in_req[g]),
                .dreq_o   (dma_out_req[g]),
                .res_blk  (res_w[g*128 +: 128]),
                .res_stb  (rstb_w[g])
            );
        end
    endgenerate

    always @*
    begin
        rd_nxt = 32'h0;
        if (is_eng)
        begin
            if (off == `DAE_CTRL)
                rd_nxt = {15'h0, 1'b0, ca[15:0]};
            else if (off == `DAE_STAT)
                rd_nxt = {28'h0, eok[es], busy_w[es], err_w[es], ccf_w[es]};
            else if (off == `DAE_DOUT)
                rd_nxt = dout_w[es*32 +: 32];
            else if (is_iv)
                rd_nxt = iv_w[es*128 + paddr[3:2]*32 +: 32];
        end
        // key and boot words fall through as zero
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r[0] <= 17'h0;
            ctrl_r[1] <= 17'h0;
            swkey_r[0] <= 256'h0;
            swkey_r[1] <= 256'h0;
            kok_r <= 2'h0;
            hwk_r <= 2'h0;
            boot_key_r <= 256'h0;
            boot_lock_r <= 1'b0;
            breach_r <= 1'b0;
            wh_r <= 1'b0;
            s1_r <= 3'h0;
            s2_r <= 3'h0;
            prdata_r <= 32'h0;
            perr_r <= 1'b0;
        end
        else
        begin
            s1_r <= {security_breach, rdp_regression, tamper};
            s2_r <= s1_r;
            if (breach_s)
                breach_r <= 1'b1;
            if (psel & ~penable)
            begin
                prdata_r <= bad ? 32'h0 : rd_nxt;
                perr_r <= bad;
            end
            if (wr & is_eng & (off == `DAE_CTRL))
            begin
                ctrl_r[es] <= es ? (pwdata[16:0] & `DAE_FAST_MASK) : {1'b0, pwdata[15:0]};
                if (~es & pwdata[`DAE_C_SHARE])
                begin
                    swkey_r[1] <= sec_key;
                    kok_r[1] <= sec_ok;
                    hwk_r[1] <= (cs[`DAE_C_KSEL] != 2'h0) | hwk_r[0];
                end
            end
            if (wr & is_eng & is_key)
            begin
                swkey_r[es][kidx*32 +: 32] <= pwdata;
                hwk_r[es] <= 1'b0;
                if (kidx == 3'h0)
                    kok_r[es] <= 1'b0;
                if (kidx == (ca[`DAE_C_KSZ] ? 3'h7 : 3'h3))
                    kok_r[es] <= 1'b1;
            end
            if (unwrap)
            begin
                wh_r <= cs[`DAE_C_KSZ] & ~wh_r;
                if (cs[`DAE_C_KMODE] == `DAE_KM_SHARE)
                begin
                    swkey_r[1][wh_r*128 +: 128] <= res_w[127:0];
                    kok_r[1] <= ~cs[`DAE_C_KSZ] | wh_r;
                    hwk_r[1] <= (cs[`DAE_C_KSEL] != 2'h0);
                end
                else if (cs[`DAE_C_KMODE] == `DAE_KM_WRAP)
                begin
                    swkey_r[0][wh_r*128 +: 128] <= res_w[127:0];
                    kok_r[0] <= ~cs[`DAE_C_KSZ] | wh_r;
                    hwk_r[0] <= (cs[`DAE_C_KSEL] != 2'h0);
                end
            end
            if (wr & (sel == `DAE_SEL_BOOT) & ~boot_lock_r)
            begin
                boot_key_r[kidx*32 +: 32] <= pwdata;
                if (kidx == 3'h7)
                    boot_lock_r <= 1'b1;
            end
            if (tamper_s | rdp_s)
                boot_key_r <= 256'h0;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = perr_r;
    assign pready = 1'b1;
endmodule // dae_top

// ---- tb/dae_chk.sv ----
// concurrent checks on the accelerator's top-level ports
`timescale 1ns/10ps
module dae_chk (
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb slave side
    input wire [11:0] paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // dma requests
    input wire [1:0]  dma_in_req,
    input wire [1:0]  dma_out_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc    = psel && penable;
    wire rd_acc = acc && !pwrite;
    wire bad    = paddr[11:10] != 2'h0 || paddr[9:8] == 2'h3 || paddr[1:0] != 2'h0;
    wire eng_lo = !bad && paddr[9:8] != 2'h2 && paddr[7:0] <= 8'h10;

    pready_hi_a: assert property (pready)
        else $error("pready low");
    unmap_err_a: assert property (acc && bad |-> pslverr)
        else $error("unmapped access not refused");
    map_ok_a: assert property (acc && eng_lo |-> !pslverr)
        else $error("mapped access refused");
    key_rd_a: assert property (rd_acc && !bad && paddr[7:5] == 3'h1 |-> prdata == 32'h0)
        else $error("key register read gave data");
    boot_rd_a: assert property (rd_acc && paddr[9:8] == 2'h2 && paddr[7:5] == 3'h0 |-> prdata == 32'h0)
        else $error("boot key read gave data");
    err_zero_a: assert property (acc && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    rd_hold_a: assert property (acc |=> $stable(prdata))
        else $error("read data moved after access");
    stat_hi_a: assert property (rd_acc && eng_lo && paddr[7:0] == 8'h04 |-> prdata[31:4] == 28'h0)
        else $error("status upper bits set");
    dma_excl_a: assert property ((dma_in_req & dma_out_req) == 2'h0)
        else $error("input and output request together");
    rst_quiet_a: assert property ($rose(presetn) |-> dma_in_req == 2'h0 && dma_out_req == 2'h0)
        else $error("dma request out of reset");
endmodule // dae_chk

bind dae_top dae_chk dae_chk_i (
    .pclk        (pclk),
    .presetn     (presetn),
    .paddr       (paddr),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .dma_in_req  (dma_in_req),
    .dma_out_req (dma_out_req)
);

// ---- tb/dae_host.sv ----
// apb host and dma channel model facing the accelerator
`timescale 1ns/10ps
module dae_host (
    // clock
    input  wire         pclk,
    // apb master
    output logic [11:0] paddr,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [31:0] pwdata,
    input  wire  [31:0] prdata,
    input  wire         pready,
    input  wire         pslverr,
    // dma input requests
    input  wire  [1:0]  dma_in_req
);
    initial {paddr, psel, penable, pwrite, pwdata} = '0;

    task xfer(input [11:0] a, input w, input [31:0] d, output [31:0] q, output e);
        @(posedge pclk);
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        psel    <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep a usable stale value
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask

    // one single write per input request, one word at a time
    task dma_wr(input i, input [11:0] a, input [31:0] d);
        logic [31:0] q;
        logic        e;
        #1;
        for (int n = 0; n < 1000 && dma_in_req[i] !== 1'b1; n++)
        begin
            @(posedge pclk);
            #1;
        end
        xfer(a, 1'b1, d, q, e);
    endtask
endmodule // dae_host

// ---- tb/dae_top_test.sv ----
// self-checking bench for the dual cipher accelerator
`timescale 1ns/10ps
`include "dae_defs.vh"
module dae_top_test;
    logic         pclk            = 1'b0;
    logic         presetn         = 1'b0;
    logic [255:0] root_device_key = '0;
    logic [31:0]  rng_data        = 32'h0;
    logic         tamper          = 1'b0;
    logic         rdp_regression  = 1'b0;
    logic         security_breach = 1'b0;
    wire  [11:0]  paddr;
    wire          psel;
    wire          penable;
    wire          pwrite;
    wire  [31:0]  pwdata;
    wire  [31:0]  prdata;
    wire          pready;
    wire          pslverr;
    wire  [1:0]   dma_in_req;
    wire  [1:0]   dma_out_req;
    integer       err_total       = 0;
    integer       check_count     = 0;
    logic [31:0]  q;
    logic         e;
    int           lat;
    logic [127:0] x, iv, res, c0, r256;
    logic [255:0] k, k2;

    always #12.5 pclk = ~pclk;
    // mask input changes every cycle; results must not depend on it
    always @(posedge pclk) rng_data <= $urandom;

    dae_top dae_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .root_device_key(root_device_key), .rng_data(rng_data), .tamper(tamper),
        .rdp_regression(rdp_regression), .security_breach(security_breach),
        .dma_in_req(dma_in_req), .dma_out_req(dma_out_req));
    dae_host dae_host_i (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dma_in_req(dma_in_req));

    task end_sim;
        if (err_total == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input logic [127:0] s, input logic [127:0] xp);
        check_count++;
        if (s !== xp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, xp);
        end
    endtask

    function automatic logic [31:0] sw(input logic [31:0] w, input logic [1:0] s);
        case (s)
            2'h1: sw = {w[15:0], w[31:16]};
            2'h2: sw = {w[7:0], w[15:8], w[23:16], w[31:24]};
            2'h3: sw = {<<{w}};
            default: sw = w;
        endcase
    endfunction

    task wr(input [11:0] a, input [31:0] d);
        dae_host_i.xfer(a, 1'b1, d, q, e);
    endtask
    task rd(input [11:0] a);
        dae_host_i.xfer(a, 1'b0, 32'h0, q, e);
    endtask
    task key(input [11:0] b, input [255:0] kv, input int n);
        for (int i = 0; i < n; i++) wr(12'(b + 12'h20 + 4 * i), kv[32 * i +: 32]);
    endtask
    task setiv;
        for (int w = 0; w < 4; w++) wr(12'(12'h140 + 4 * w), iv[32 * w +: 32]);
    endtask
    // first word carries the top of the block
    task start(input i, input [31:0] c, input [127:0] d);
        wr({3'h0, i, 8'h00}, c | 32'h3001);
        for (int w = 3; w >= 0; w--) dae_host_i.dma_wr(i, {3'h0, i, 8'h0C}, sw(d[32 * w +: 32], c[7:6]));
    endtask
    task finish(input i);
        lat = 0;
        do
        begin
            @(posedge pclk);
            #1;
            lat++;
        end
        while (dma_out_req[i] !== 1'b1 && lat < 2000);
        for (int w = 3; w >= 0; w--)
        begin
            rd({3'h0, i, 8'h10});
            res[32 * w +: 32] = q;
        end
        #1;
        chk(dma_out_req[i], 1'b0);
    endtask
    task blk(input i, input [31:0] c, input [127:0] d);
        start(i, c, d);
        finish(i);
    endtask

    initial
    begin
        void'($urandom(32'h9494));
        for (int j = 0; j < 8; j++)
        begin
            k[32 * j +: 32]               = $urandom;
            k2[32 * j +: 32]              = $urandom;
            root_device_key[32 * j +: 32] = $urandom;
        end
        x  = {$urandom, $urandom, $urandom, $urandom};
        iv = {$urandom, $urandom, $urandom, $urandom};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h104);
        chk(q, 32'h0);
        rd(12'h300);
        chk({e, q}, {1'b1, 32'h0});
        rd(12'h002);
        chk({e, q}, {1'b1, 32'h0});
        // a partly rewritten key must not run
        wr(12'h000, 32'h1);
        key(12'h000, k, 4);
        wr(12'h020, k[63:32]);
        for (int w = 0; w < 4; w++) wr(12'h00C, x[32 * w +: 32]);
        rd(12'h004);
        chk(q, 32'h2);
        wr(12'h008, 32'h3);
        wr(12'h100, 32'h1);
        key(12'h100, k, 4);
        rd(12'h120);
        chk(q, 32'h0);
        for (int s = 0; s < 4; s++)
        begin
            blk(1'b1, 32'(s) << 6, x);
            chk(lat, 51);
            if (s == 0)
                c0 = res;
            for (int w = 0; w < 4; w++) chk(res[32 * w +: 32], sw(c0[32 * w +: 32], 2'(s)));
        end
        key(12'h000, k, 4);
        blk(1'b0, 32'h0, x);
        chk(lat, 528);
        chk(res, c0);
        wr(12'h100, 32'h21);
        key(12'h100, k2, 8);
        blk(1'b1, 32'h20, x);
        chk(lat, 75);
        wr(12'h000, 32'h21);
        key(12'h000, k, 8);
        blk(1'b0, 32'h20, x);
        chk(lat, 743);
        r256 = res;
        wr(12'h000, 32'h1_0021);
        blk(1'b1, 32'h20, x);
        chk(res, r256);
        key(12'h000, {128'h0, x}, 8);
        blk(1'b0, 32'h0, x);
        c0 = res;
        start(1'b0, 32'h802, c0);
        repeat (530) @(posedge pclk);
        blk(1'b1, 32'h0, x);
        chk(res, c0);
        for (int m = 0; m < 6; m++)
        begin
            setiv;
            rd(12'h14C);
            chk(q, iv[127:96]);
            blk(1'b1, 32'h20 | 32'(m) << 2, x);
            c0 = res;
            rd(12'h140);
            if (m == 2)
                chk(q, iv[31:0] + 32'h1);
            setiv;
            if (m != 4)
            begin
                blk(1'b1, 32'h22 | 32'(m) << 2, c0);
                chk(res, x);
            end
        end
        for (int t = 0; t < 2; t++)
        begin
            wr(12'h000, 32'h21);
            key(12'h000, root_device_key ^ {8{t == 0 ? `DAE_CTX_S : `DAE_CTX_N}}, 8);
            blk(1'b0, 32'h20, x);
            c0 = res;
            start(1'b0, t == 0 ? 32'h8120 : 32'h120, x);
            wr(12'h00C, 32'h0);
            rd(12'h004);
            chk(q[2:1], 2'h3);
            finish(1'b0);
            chk(res, c0);
            wr(12'h008, 32'h3);
        end
        for (int j = 0; j < 8; j++) wr(12'(12'h200 + 4 * j), k2[32 * j +: 32]);
        rd(12'h204);
        chk(q, 32'h0);
        blk(1'b0, 32'h220, x);
        c0 = res;
        for (int j = 0; j < 8; j++) wr(12'(12'h200 + 4 * j), k[32 * j +: 32]);
        blk(1'b0, 32'h220, x);
        chk(res, c0);
        wr(12'h000, 32'h21);
        key(12'h000, k2, 8);
        blk(1'b0, 32'h20, x);
        chk(res, c0);
        @(posedge pclk) tamper <= 1'b1;
        repeat (4) @(posedge pclk);
        tamper <= 1'b0;
        repeat (4) @(posedge pclk);
        key(12'h000, 256'h0, 8);
        blk(1'b0, 32'h20, x);
        c0 = res;
        blk(1'b0, 32'h220, x);
        chk(res, c0);
        @(posedge pclk) security_breach <= 1'b1;
        repeat (4) @(posedge pclk);
        wr(12'h008, 32'h3);
        wr(12'h000, 32'h121);
        for (int w = 0; w < 4; w++) wr(12'h00C, x[32 * w +: 32]);
        rd(12'h004);
        chk(q[3:0], 4'h2);
        wr(12'h100, 32'h7001);
        #1 chk(dma_in_req[1], 1'b0);
        end_sim;
    end

    initial
    begin
        #1_500_000;
        err_total++;
        end_sim;
    end
endmodule // dae_top_test
